// ==== hdl/rbn_ctrl.sv ====
// reset, boot source and nmi control
// Behaviour
// - a low external access select during and after reset selects boot from external memory.
// - a high external access select selects execution from internal program memory.
// - a low reset input pin while the oscillator runs puts the device into reset.
// - low pulses under 10 ns on the reset input are rejected and those over 100 ns pass.
// - with bidirectional reset enabled the device pulls the reset pin low during each sequence.
// - the reset indication output goes low on every hardware, software or watchdog reset.
// - the reset indication output stays low until end of init executes, then goes high.
// - a falling edge on the nmi input during run or init raises a trap request to the cpu.
// - the power down instruction with nmi low enters power down mode.
// - the power down instruction with nmi high is ignored and the device keeps running.
`include "rbn_defines.svh"
`default_nettype none
module rbn_ctrl #(
	parameter int SEQ_CYC = `RBN_SEQ_CYC,
	parameter int FILT_CYC = `RBN_FILT_CYC
) (
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic RESET_INPUT_PIN_I,
	input wire logic EXTERNAL_ACCESS_SELECT_I,
	input wire logic NMI_I,
	input wire logic SW_RESET_I,
	input wire logic WDT_RESET_I,
	input wire logic BIDIR_RESET_ENABLE_BIT_I,
	input wire logic END_OF_INIT_INSTRUCTION_I,
	input wire logic POWER_DOWN_INSTRUCTION_I,
	input wire logic WAKE_I,
	output logic RESET_INPUT_PIN_O,
	output logic RESET_INPUT_PIN_OE_O,
	output logic RESET_INDICATION_OUTPUT_O,
	output logic CORE_RESET_O,
	output logic BOOT_INTERNAL_O,
	output logic NMI_TRAP_O,
	output logic POWER_DOWN_O
);
	rbn_pkg::rbn_state_t state_ff;
	rbn_pkg::rbn_state_t nxt_state;
	logic [7:0] seq_cnt_ff;
	logic rst_lvl;
	logic nmi_lvl;
	logic nmi_prev_ff;
	logic rstpin_low;
	logic int_reset_req;
	rbn_pkg::rbn_boot_t boot_ff;
	logic bidir_ff;
	logic pin_oe_ff;
	logic reset_indication_output_ff;
	logic core_rst_ff;
	logic trap_ff;
	logic pdown_ff;
	logic [7:0] self_mask_ff;
	logic [7:0] pin_run_ff;

	if (SEQ_CYC < 2 || SEQ_CYC > 255) begin : g_bad_seq
		$error("rbn_ctrl: SEQ_CYC out of range");
	end
	if (FILT_CYC <= `RBN_REJECT_CYC || FILT_CYC > `RBN_PASS_CYC) begin : g_bad_filt
		$error("rbn_ctrl: FILT_CYC cannot meet the spike limits");
	end

	// filter sits behind the synchroniser so only synchronised samples reach it; it drops pulses under FILT_CYC cycles
	rbn_sync_filter #(.FILT_CYC(FILT_CYC), .RST_VAL(1'b1)) u_rst_filt (
		.clock_i(CLOCK_I),
		.rst_i(RST_I),
		.pin_i(RESET_INPUT_PIN_I),
		.level_o(rst_lvl)
	);

	rbn_sync_filter #(.FILT_CYC(2), .RST_VAL(1'b1)) u_nmi_filt (
		.clock_i(CLOCK_I),
		.rst_i(RST_I),
		.pin_i(NMI_I),
		.level_o(nmi_lvl)
	);

	// filtered pin lags our own release by sync plus filter depth; without the mask the
	// tail of our own pull would restart the sequence forever in bidirectional mode
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			self_mask_ff <= 8'h00;
		end else if (pin_oe_ff) begin
			self_mask_ff <= 8'(FILT_CYC + 2);
		end else if (self_mask_ff != 8'h00) begin
			self_mask_ff <= self_mask_ff - 8'h01;
		end
	end

	// limitation: an outside press overlapping our own pull is seen once the mask runs out
	assign rstpin_low = !rst_lvl && !pin_oe_ff && (self_mask_ff == 8'h00);

	// length of the current low run on the raw pin, only for the filter check
	always_ff @(posedge CLOCK_I) begin
		if (RST_I || RESET_INPUT_PIN_I) begin
			pin_run_ff <= 8'h00;
		end else if (pin_run_ff != 8'hFF) begin
			pin_run_ff <= pin_run_ff + 8'h01;
		end
	end
	assign int_reset_req = SW_RESET_I || WDT_RESET_I;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			rbn_pkg::RBN_RUN: begin
				if (POWER_DOWN_INSTRUCTION_I && !nmi_lvl) begin
					nxt_state = rbn_pkg::RBN_PDOWN;
				end
			end
			rbn_pkg::RBN_SEQ: begin
				if (seq_cnt_ff == 8'h00 && !rstpin_low) begin
					nxt_state = rbn_pkg::RBN_INIT;
				end
			end
			rbn_pkg::RBN_INIT: begin
				if (END_OF_INIT_INSTRUCTION_I) begin
					nxt_state = rbn_pkg::RBN_RUN;
				end
			end
			rbn_pkg::RBN_PDOWN: begin
				if (WAKE_I) begin
					nxt_state = rbn_pkg::RBN_RUN;
				end
			end
			default: begin
				nxt_state = rbn_pkg::RBN_SEQ;
			end
		endcase
		if (rstpin_low || int_reset_req) begin
			nxt_state = rbn_pkg::RBN_SEQ;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			state_ff <= rbn_pkg::RBN_SEQ;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			seq_cnt_ff <= 8'(SEQ_CYC - 1);
		end else if (rstpin_low || int_reset_req) begin
			seq_cnt_ff <= 8'(SEQ_CYC - 1);
		end else if (state_ff == rbn_pkg::RBN_SEQ && seq_cnt_ff != 8'h00) begin
			seq_cnt_ff <= seq_cnt_ff - 8'h01;
		end
	end

	// boot source latched while in reset, frozen once the sequence ends
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			boot_ff <= rbn_pkg::RBN_BOOT_EXT;
		end else if (nxt_state == rbn_pkg::RBN_SEQ) begin
			boot_ff <= EXTERNAL_ACCESS_SELECT_I ? rbn_pkg::RBN_BOOT_INT
				: rbn_pkg::RBN_BOOT_EXT;
		end
	end

	// enable bit lives in system_config_register and clears on reset
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			bidir_ff <= 1'b0;
		end else begin
			bidir_ff <= BIDIR_RESET_ENABLE_BIT_I;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			pin_oe_ff <= 1'b0;
		end else begin
			pin_oe_ff <= bidir_ff && (nxt_state == rbn_pkg::RBN_SEQ);
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			reset_indication_output_ff <= 1'b0;
		end else begin
			reset_indication_output_ff <= (nxt_state == rbn_pkg::RBN_RUN)
				|| (nxt_state == rbn_pkg::RBN_PDOWN);
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			core_rst_ff <= 1'b1;
		end else begin
			core_rst_ff <= (nxt_state == rbn_pkg::RBN_SEQ);
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			nmi_prev_ff <= 1'b1;
			trap_ff <= 1'b0;
		end else begin
			nmi_prev_ff <= nmi_lvl;
			trap_ff <= nmi_prev_ff && !nmi_lvl && (state_ff == rbn_pkg::RBN_RUN
				|| state_ff == rbn_pkg::RBN_INIT);
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			pdown_ff <= 1'b0;
		end else begin
			pdown_ff <= (nxt_state == rbn_pkg::RBN_PDOWN);
		end
	end

	assign RESET_INPUT_PIN_O = 1'b0;
	assign RESET_INPUT_PIN_OE_O = pin_oe_ff;
	assign RESET_INDICATION_OUTPUT_O = reset_indication_output_ff;
	assign CORE_RESET_O = core_rst_ff;
	assign BOOT_INTERNAL_O = (boot_ff == rbn_pkg::RBN_BOOT_INT);
	assign NMI_TRAP_O = trap_ff;
	assign POWER_DOWN_O = pdown_ff;

	AST_PDOWN_ENTRY: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(state_ff == rbn_pkg::RBN_RUN && POWER_DOWN_INSTRUCTION_I && !nmi_lvl
		&& !rstpin_low && !int_reset_req) |=> POWER_DOWN_O)
		else $error("power down not entered");
	AST_PDOWN_IGNORED: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(state_ff == rbn_pkg::RBN_RUN && nmi_lvl) |=> !POWER_DOWN_O)
		else $error("power down taken with nmi high");
	AST_RESET_ENTRY: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		rstpin_low |=> CORE_RESET_O && !RESET_INDICATION_OUTPUT_O)
		else $error("reset pin low did not reset");
	AST_SOFT_RESET: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(SW_RESET_I || WDT_RESET_I) |=> !RESET_INDICATION_OUTPUT_O)
		else $error("indication not low on internal reset");
	AST_HOLD_TO_END_OF_INIT_INSTRUCTION: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(state_ff == rbn_pkg::RBN_INIT && !END_OF_INIT_INSTRUCTION_I) |=> !RESET_INDICATION_OUTPUT_O)
		else $error("indication released before end of init");
	AST_RELEASE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(state_ff == rbn_pkg::RBN_INIT && END_OF_INIT_INSTRUCTION_I && !rstpin_low
		&& !int_reset_req) |=> RESET_INDICATION_OUTPUT_O)
		else $error("indication not released");
	AST_BIDIR_DRIVE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(bidir_ff && int_reset_req) |=> RESET_INPUT_PIN_OE_O)
		else $error("reset pin not driven in bidirectional mode");
	AST_NO_DRIVE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		!bidir_ff |=> !RESET_INPUT_PIN_OE_O)
		else $error("reset pin driven with mode off");
	AST_NMI_TRAP: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		($fell(nmi_lvl) && state_ff == rbn_pkg::RBN_RUN) |=> NMI_TRAP_O)
		else $error("nmi edge gave no trap");
	AST_BOOT_SRC: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(state_ff == rbn_pkg::RBN_SEQ && !rstpin_low && !int_reset_req && seq_cnt_ff != 8'h00)
		|=> BOOT_INTERNAL_O == $past(EXTERNAL_ACCESS_SELECT_I))
		else $error("boot source not latched");
	AST_FILTER: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		$fell(rst_lvl) |-> $past(pin_run_ff, 2) >= 8'(FILT_CYC))
		else $error("reset filter passed a short pulse");
	AST_TRAP_PULSE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		NMI_TRAP_O |=> !NMI_TRAP_O)
		else $error("trap request longer than one cycle");
	AST_NO_TRAP_IN_SEQ: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(state_ff == rbn_pkg::RBN_SEQ) |=> !NMI_TRAP_O)
		else $error("trap raised during reset sequence");
	AST_BOOT_FROZEN: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(nxt_state != rbn_pkg::RBN_SEQ) |=> $stable(BOOT_INTERNAL_O))
		else $error("boot source changed outside reset");
	AST_DRIVE_WHOLE_SEQ: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(bidir_ff && state_ff == rbn_pkg::RBN_SEQ && seq_cnt_ff != 8'h00)
		|=> RESET_INPUT_PIN_OE_O)
		else $error("reset pin released inside the sequence");
	AST_NO_SELF_RETRIGGER: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(state_ff == rbn_pkg::RBN_INIT && self_mask_ff != 8'h00 && !int_reset_req)
		|=> !CORE_RESET_O)
		else $error("own pull of the reset pin restarted the sequence");
	AST_PDOWN_HOLD: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(state_ff == rbn_pkg::RBN_PDOWN && !WAKE_I && !rstpin_low && !int_reset_req)
		|=> POWER_DOWN_O)
		else $error("power down left without wake");
	AST_SEQ_IND_LOW: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		$rose(CORE_RESET_O) |-> !RESET_INDICATION_OUTPUT_O)
		else $error("indication high while reset starts");
	AST_INIT_AFTER_SEQ: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		$fell(CORE_RESET_O) |-> (state_ff == rbn_pkg::RBN_INIT && !RESET_INDICATION_OUTPUT_O))
		else $error("indication released before end of init");
	AST_RUN_HOLDS_IND: assert property (@(posedge CLOCK_I) disable iff (RST_I)
		(state_ff == rbn_pkg::RBN_RUN && !rstpin_low && !int_reset_req)
		|=> RESET_INDICATION_OUTPUT_O)
		else $error("indication dropped while running");
endmodule : rbn_ctrl
`default_nettype wire

// ==== hdl/rbn_defines.svh ====
// timing counts for the reset, boot and nmi control block
`ifndef RBN_DEFINES_SVH
`define RBN_DEFINES_SVH
`define RBN_CLK_PERIOD_PS 4000
`define RBN_SPIKE_REJECT_PS 10000
`define RBN_SPIKE_PASS_PS 100000
// longest rejected pulse rounds down, pass length rounds up
`define RBN_REJECT_CYC (`RBN_SPIKE_REJECT_PS / `RBN_CLK_PERIOD_PS)
`define RBN_PASS_CYC ((`RBN_SPIKE_PASS_PS + `RBN_CLK_PERIOD_PS - 1) / `RBN_CLK_PERIOD_PS)
`define RBN_FILT_CYC 3
`define RBN_SEQ_CYC 16
`endif

// ==== hdl/rbn_pkg.sv ====
// types for the reset, boot and nmi control block
`default_nettype none
package rbn_pkg;
	typedef enum logic [1:0] {
		RBN_RUN,
		RBN_SEQ,
		RBN_INIT,
		RBN_PDOWN
	} rbn_state_t;
	typedef enum logic {
		RBN_BOOT_EXT,
		RBN_BOOT_INT
	} rbn_boot_t;
endpackage : rbn_pkg
`default_nettype wire

// ==== hdl/rbn_sync_filter.sv ====
// two-flop synchroniser followed by a glitch filter for one pin
`default_nettype none
module rbn_sync_filter #(
	parameter int FILT_CYC = 3,
	parameter logic RST_VAL = 1'b1
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic level_o
);
	logic meta_ff;
	logic sync_ff;
	logic [7:0] cnt_ff;
	logic level_ff;

	if (FILT_CYC < 1 || FILT_CYC > 255) begin : g_bad_filt
		$error("rbn_sync_filter: FILT_CYC out of range");
	end

	// only sync_ff reads meta_ff
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= pin_i;
			sync_ff <= meta_ff;
		end
	end

	// level changes only after the new value held FILT_CYC cycles
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cnt_ff <= 8'h00;
			level_ff <= RST_VAL;
		end else if (sync_ff == level_ff) begin
			cnt_ff <= 8'h00;
		end else if (cnt_ff == 8'(FILT_CYC - 1)) begin
			cnt_ff <= 8'h00;
			level_ff <= sync_ff;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end

	assign level_o = level_ff;
endmodule : rbn_sync_filter
`default_nettype wire

// ==== testbench/rbn_board.sv ====
// board reset circuitry and supervisor model for the reset, boot and nmi pins
`default_nettype none
module rbn_board #(
	parameter logic ROMLESS = 1'b0
) (
	input wire logic clock_i,
	input wire logic ea_sel_i,
	input wire logic nmi_low_i,
	input wire logic dev_oe_i,
	input wire logic dev_pin_i,
	output logic rst_pin_o,
	output logic ea_o,
	output logic nmi_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hold_low = 1'b0;
	// open-drain line with pull-up: low while either party pulls it
	assign rst_pin_o = ~(hold_low | (dev_oe_i & ~dev_pin_i));
	// romless boards tie the select low
	assign ea_o = ROMLESS ? 1'b0 : ea_sel_i;
	// unused nmi rests high through the pull-up
	assign nmi_o = ~nmi_low_i;
	// press length in clocks; the long settle time is cut short to keep runs brief
	task automatic press(input int cyc);
		@(posedge clock_i);
		hold_low <= 1'b1;
		repeat (cyc) @(posedge clock_i);
		hold_low <= 1'b0;
	endtask : press
endmodule : rbn_board
`default_nettype wire

// ==== testbench/rbn_ctrl_test.sv ====
// self-checking bench for the reset, boot and nmi control block
`default_nettype none
module rbn_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, ea = 1'b1, nmi_low = 1'b0, sw = 1'b0, wdt = 1'b0;
	logic bidir = 1'b0, eoi = 1'b0, pdi = 1'b0, wake = 1'b0;
	wire logic pin, ea_pin, nmi, pin_o, pin_oe, ind, core, boot, trap, pdown;
	int failures = 0, checked = 0, cycles = 0;
	always #2 clk = ~clk;
	rbn_board #(.ROMLESS(1'b0)) u_board (.clock_i(clk), .ea_sel_i(ea), .nmi_low_i(nmi_low),
		.dev_oe_i(pin_oe), .dev_pin_i(pin_o), .rst_pin_o(pin), .ea_o(ea_pin), .nmi_o(nmi));
	rbn_ctrl #(.SEQ_CYC(4), .FILT_CYC(3)) u_dut (.CLOCK_I(clk), .RST_I(rst),
		.RESET_INPUT_PIN_I(pin), .EXTERNAL_ACCESS_SELECT_I(ea_pin), .NMI_I(nmi),
		.SW_RESET_I(sw), .WDT_RESET_I(wdt), .BIDIR_RESET_ENABLE_BIT_I(bidir),
		.END_OF_INIT_INSTRUCTION_I(eoi), .POWER_DOWN_INSTRUCTION_I(pdi), .WAKE_I(wake),
		.RESET_INPUT_PIN_O(pin_o), .RESET_INPUT_PIN_OE_O(pin_oe),
		.RESET_INDICATION_OUTPUT_O(ind), .CORE_RESET_O(core), .BOOT_INTERNAL_O(boot),
		.NMI_TRAP_O(trap), .POWER_DOWN_O(pdown));
	task automatic check(input string what, input logic seen, input logic exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %b seen %b", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	// hang guard: the whole run needs well under a thousand clocks
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			end_of_test();
		end
	end
	// wait out the sequence, then end init and expect the indication released
	task automatic finish_seq();
		int n;
		n = 0;
		while (core !== 1'b0 && n < 60) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("core_reset", core, 1'b0);
		repeat (3) @(posedge clk);
		#1;
		check("indication", ind, 1'b0);
		@(posedge clk);
		eoi <= 1'b1;
		@(posedge clk);
		eoi <= 1'b0;
		#1;
		check("indication", ind, 1'b1);
	endtask : finish_seq
	task automatic t_src(input logic use_wdt, input logic bd, input logic ea_v);
		@(posedge clk);
		bidir <= bd;
		ea <= ea_v;
		repeat (2) @(posedge clk);
		sw <= ~use_wdt;
		wdt <= use_wdt;
		@(posedge clk);
		sw <= 1'b0;
		wdt <= 1'b0;
		#1;
		check("core_reset", core, 1'b1);
		check("indication", ind, 1'b0);
		check("pin_drive", pin_oe, bd);
		check("pin_level", pin, ~bd);
		finish_seq();
		check("boot_internal", boot, ea_v);
	endtask : t_src
	task automatic t_pin();
		u_board.press(1);
		repeat (10) @(posedge clk);
		#1;
		check("core_reset", core, 1'b0);
		fork
			u_board.press(27);
			begin
				repeat (9) @(posedge clk);
				#1;
				check("core_reset", core, 1'b1);
				check("indication", ind, 1'b0);
			end
		join
		finish_seq();
	endtask : t_pin
	task automatic pulse_pd(input logic exp);
		@(posedge clk);
		pdi <= 1'b1;
		@(posedge clk);
		pdi <= 1'b0;
		#1;
		check("power_down", pdown, exp);
	endtask : pulse_pd
	task automatic t_nmi();
		int cnt;
		cnt = 0;
		pulse_pd(1'b0);
		@(posedge clk);
		nmi_low <= 1'b1;
		repeat (10) begin
			@(posedge clk);
			#1;
			cnt += int'(trap === 1'b1);
		end
		check("nmi_trap_count", cnt == 1, 1'b1);
		pulse_pd(1'b1);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		#1;
		check("power_down", pdown, 1'b0);
	endtask : t_nmi
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		finish_seq();
		check("boot_internal", boot, 1'b1);
		t_src(1'b0, 1'b1, 1'b0);
		t_src(1'b1, 1'b0, 1'b1);
		t_pin();
		t_nmi();
		end_of_test();
	end
endmodule : rbn_ctrl_test
`default_nettype wire
